// ===== bench/tb_top.sv
// self-checking bench for the reload capture timer over its bus
`timescale 1ns/1ns
module tb_top;
   import rct_pkg::*;
   // ==========================================
   // signals
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] osc = 2'h0; // bit0 rtc, bit1 external oscillator
   logic irq;
   rct_ahb_in_type ahb_in;
   rct_ahb_out_type ahb_out;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0000_002E;
   logic [31:0] v1, v2, rl, q;
   // single slave, so its hreadyout is the bus hready
   assign ahb_in = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
      hsize: 3'h2, hwdata: hwdata, hready: ahb_out.hreadyout};
   rct_timer u_rct_timer (.clk(clk), .sys_rst(sys_rst), .ahb_in(ahb_in), .ahb_out(ahb_out),
      .rtc_osc(osc[0]), .ext_osc(osc[1]), .irq(irq));
   // ==========================================
   // clock and hang guard
   initial begin
      forever #5 clk = ~clk;
   end
   // ceiling well above the whole sequence length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         close_out();
      end
   end
   // ==========================================
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one single transfer; waits on hready, never on a fixed count
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (ahb_out.hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (ahb_out.hreadyout !== 1'b1);
      r = ahb_out.hrdata;
      chk({31'h0000_0000, ahb_out.hresp}, RST32);
      // released data lines do not keep the last value
      hwdata <= ~d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0000_0000, r);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // range compare for counts that move while the bus works
   task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask
   // oscillator pulses: high for hi cycles, low for 3, so period hi+3
   task automatic pulse(input logic sel, input int n, input int hi);
      repeat (n) begin
         @(posedge clk);
         osc[sel] <= 1'b1;
         idle(hi);
         osc[sel] <= 1'b0;
         idle(2);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial begin
      idle(10);
      sys_rst <= 1'b0;
      // reset values of every word, unmapped one included
      for (int a = 0; a <= 28; a += 4) begin
         rd(8'(a), v1);
         chk(v1, RST32);
      end
      wr(8'h1C, rnd());
      rd(8'h1C, v1);
      chk(v1, RST32);
      // byte registers keep only their low byte, random data
      for (int a = 0; a <= 12; a += 4) begin
         v2 = rnd();
         wr(8'(a), v2);
         rd(8'(a), v1);
         chk(v1, v2 & 32'h0000_00FF);
      end
      // wrap reloads and raises a lasting flag
      rl = rnd() & 32'h0000_7FFF;
      wr(OFF_RLD_L, rl & 32'h0000_00FF);
      wr(OFF_RLD_H, rl >> 8);
      wr(OFF_CNT_L, 32'h0000_00F0);
      wr(OFF_CNT_H, 32'h0000_00FF);
      wr(OFF_CLOCK_CONTROL_REGISTER, 32'h0000_0001);
      wr(OFF_IEN, 32'h0000_0080);
      wr(OFF_CTRL, 32'h0000_0004);
      idle(30);
      rd(OFF_CTRL, v1);
      chk(v1, 32'h0000_00C4);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      idle(20);
      rd(OFF_CTRL, v1);
      chk(v1, 32'h0000_00C4);
      wr(OFF_CTRL, 32'h0000_00C0);
      rd(OFF_CNT_H, v2);
      rd(OFF_CNT_L, v1);
      rng({16'h0000, v2[7:0], v1[7:0]} - rl, 32'h0000_002A, 32'h0000_002C);
      wr(OFF_CTRL, RST32);
      idle(2);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      // low byte wrap requests only with its enable
      wr(OFF_CNT_L, 32'h0000_00F8);
      wr(OFF_CNT_H, RST32);
      wr(OFF_CTRL, 32'h0000_0024);
      idle(20);
      rd(OFF_CTRL, v1);
      chk(v1, 32'h0000_0064);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      wr(OFF_CTRL, 32'h0000_0044);
      idle(2);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      wr(OFF_CTRL, RST32);
      // split bytes, low runs without run bit
      rl = rnd() & 32'h0000_003F;
      wr(OFF_RLD_L, rl);
      wr(OFF_CNT_L, 32'h0000_00F0);
      wr(OFF_CNT_H, 32'h0000_00F0);
      wr(OFF_CLOCK_CONTROL_REGISTER, 32'h0000_0003);
      wr(OFF_CTRL, 32'h0000_0028);
      idle(40);
      rd(OFF_CNT_L, v1);
      rng(v1, rl + 15, rl + 45);
      rd(OFF_CNT_H, v1);
      chk(v1, 32'h0000_00F0);
      rd(OFF_CTRL, v1);
      chk(v1, 32'h0000_0068);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      wr(OFF_CTRL, 32'h0000_002C);
      idle(30);
      rd(OFF_CTRL, v1);
      chk(v1, 32'h0000_00AC);
      wr(OFF_CTRL, RST32);
      wr(OFF_CLOCK_CONTROL_REGISTER, RST32);
      wr(OFF_CNT_L, RST32);
      wr(OFF_CTRL, 32'h0000_0004);
      idle(120);
      wr(OFF_CTRL, RST32);
      rd(OFF_CNT_L, v1);
      rng(v1, 32'h0000_0009, 32'h0000_000B);
      // rtc, reserved and external /8 codes, 16 edges each
      for (int m = 1; m <= 3; m++) begin
         wr(OFF_CNT_L, RST32);
         wr(OFF_CTRL, 32'(4 + m));
         pulse(m[1], 16, 3);
         idle(5);
         wr(OFF_CTRL, RST32);
         rd(OFF_CNT_L, v1);
         chk(v1, (m == 1) ? 32'h0000_0010 : (m == 3) ? 32'h0000_0002 : RST32);
      end
      // two rtc captures 40 cycles apart
      wr(OFF_CLOCK_CONTROL_REGISTER, 32'h0000_0001);
      wr(OFF_CNT_L, RST32);
      wr(OFF_CTRL, 32'h0000_0014); // split kept clear
      fork
         pulse(1'b0, 2, 37);
         begin
            idle(12);
            rd(OFF_RLD_L, v1);
            rd(OFF_RLD_H, v2);
            rl = {16'h0000, v2[7:0], v1[7:0]};
            idle(40);
            rd(OFF_RLD_L, v1);
            rd(OFF_RLD_H, v2);
         end
      join
      chk({16'h0000, v2[7:0], v1[7:0]} - rl, 32'h0000_0028);
      rd(OFF_CTRL, v1);
      chk(v1, 32'h0000_0094);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      // capture mode wraps freely, reload byte ignored
      wr(OFF_RLD_H, 32'h0000_0080);
      wr(OFF_CNT_L, 32'h0000_00F0);
      wr(OFF_CNT_H, 32'h0000_00FF);
      idle(30);
      wr(OFF_CTRL, RST32);
      rd(OFF_CNT_H, v2);
      rd(OFF_CNT_L, v1);
      rng({16'h0000, v2[7:0], v1[7:0]}, 32'h0000_0008, 32'h0000_0028);
      // external trigger needs exactly 8 edges
      wr(OFF_CTRL, 32'h0000_0016);
      pulse(1'b1, 7, 3);
      idle(5);
      rd(OFF_CTRL, v1);
      chk(v1, 32'h0000_0016);
      pulse(1'b1, 1, 3);
      idle(5);
      rd(OFF_CTRL, v1);
      chk(v1, 32'h0000_0096);
      wr(OFF_IEN, RST32);
      idle(2);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      close_out();
   end
endmodule

// ===== verilog/rct_edge_sync.sv
// two-flop synchroniser with a one-cycle rising edge pulse
`timescale 1ns/1ns
module rct_edge_sync
   import rct_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic async_in,
   output logic rise
);

   rct_sync_type st;       // all state
   rct_sync_type next_st;  // next state

   // ==========================================
   // next state
   always_comb begin
      next_st = st;
      next_st.meta = async_in;
      // only the second stage reads the first
      next_st.stable = st.meta;
      next_st.last = st.stable;
      // one pulse per edge, never two
      next_st.rise = st.stable & ~st.last;
   end

   // ==========================================
   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rise = st.rise;

endmodule

// ===== verilog/rct_pkg.sv
// shared constants, register map and state types of the reload capture timer
package rct_pkg;

   // ==========================================
   // register byte addresses on the bus
   localparam logic [7:0] OFF_CNT_L = 8'h00;  // count_low_byte
   localparam logic [7:0] OFF_CNT_H = 8'h04;  // count_high_byte
   localparam logic [7:0] OFF_RLD_L = 8'h08;  // reload_low_byte
   localparam logic [7:0] OFF_RLD_H = 8'h0C;  // reload_high_byte
   localparam logic [7:0] OFF_CTRL = 8'h10;   // timer_control_register
   localparam logic [7:0] OFF_CLOCK_CONTROL_REGISTER = 8'h14;  // clock_control_register
   localparam logic [7:0] OFF_IEN = 8'h18;    // extended_irq_enable_register

   // ==========================================
   // field positions
   localparam int B_TFH = 7;      // high_overflow_flag
   localparam int B_TFL = 6;      // low_overflow_flag
   localparam int B_LEN = 5;      // low_byte_irq_enable
   localparam int B_CEN = 4;      // capture_enable
   localparam int B_SPLIT = 3;    // split_mode_bit
   localparam int B_RUN = 2;      // run_control_bit
   localparam int B_XCLK1 = 1;    // ext_clock_select msb
   localparam int B_XCLK0 = 0;    // ext_clock_select lsb
   localparam int B_SEL_L = 0;    // low_byte_clock_select
   localparam int B_SEL_H = 1;    // high_byte_clock_select
   localparam int B_TIMER_IE = 7; // timer interrupt enable

   // ==========================================
   // encodings, reset values and counts
   localparam logic [1:0] XCLK_DIV12 = 2'h0;   // system_clock / 12
   localparam logic [1:0] XCLK_RTC = 2'h1;     // rtc oscillator
   localparam logic [1:0] XCLK_EXT8 = 2'h3;    // external oscillator / 8
   localparam logic [3:0] SYS_DIV = 4'hC;      // system clock prescale
   localparam logic [3:0] EXT_DIV = 4'h8;      // external oscillator prescale
   localparam logic [15:0] CNT_MAX16 = 16'hFFFF;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [15:0] RST16 = 16'h0000;
   localparam logic [31:0] RST32 = 32'h0000_0000;

   // ==========================================
   // bus carriers
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } rct_ahb_in_type;

   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } rct_ahb_out_type;

   // ==========================================
   // module state records
   typedef struct packed {
      logic [15:0] cnt;     // count_high_byte:count_low_byte
      logic [15:0] rld;     // reload_high_byte:reload_low_byte
      logic tf_h;
      logic tf_l;
      logic len;
      logic cap_en;
      logic split;
      logic run;
      logic [1:0] xclk;
      logic sel_l;
      logic sel_h;
      logic irq_en;
      logic irq;
      logic wr_pend;        // write data phase pending
      logic [7:0] wr_addr;
      logic [31:0] rdata;
   } rct_state_type;

   typedef struct packed {
      logic meta;
      logic stable;
      logic last;
      logic rise;
   } rct_sync_type;

   typedef struct packed {
      logic [3:0] cnt;
      logic out;
   } rct_div_type;

endpackage

// ===== verilog/rct_pulse_div.sv
// pulse divider: one output pulse per DIVIDE input pulses
`timescale 1ns/1ns
module rct_pulse_div
   import rct_pkg::*;
#(
   parameter logic [3:0] DIVIDE = EXT_DIV
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pulse_in,
   output logic pulse_out
);

   rct_div_type st;       // all state
   rct_div_type next_st;  // next state

   // ==========================================
   // count input pulses
   always_comb begin
      next_st = st;
      next_st.out = 1'b0;
      if (pulse_in) begin
         // last pulse of the group: wrap and emit
         if (st.cnt == DIVIDE - 4'h1) begin
            next_st.cnt = 4'h0;
            next_st.out = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 4'h1;
         end
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pulse_out = st.out;

endmodule

// ===== verilog/rct_timer.sv
// reload capture timer: 16-bit / split 8-bit auto-reload and capture, AHB-Lite slave
`timescale 1ns/1ns
module rct_timer
   import rct_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input rct_ahb_in_type ahb_in,
   output rct_ahb_out_type ahb_out,
   input wire logic rtc_osc,
   input wire logic ext_osc,
   output logic irq
);

   // ==========================================
   // declarations
   rct_state_type st;        // all registered state
   rct_state_type next_st;   // next state
   logic rtc_rise;           // synchronised rtc rising edge
   logic ext_rise;           // synchronised ext osc rising edge
   logic tick12;             // system_clock / 12 tick
   logic ext8;               // external oscillator / 8 tick
   logic ext_tick;           // selected external tick
   logic tick_l;             // low byte advance tick
   logic tick_h;             // high byte advance tick
   logic trig;               // capture trigger pulse
   logic ovf_l;              // low byte wraps this cycle
   logic ovf_h;              // high byte or 16-bit wraps
   logic cap_set;            // capture load this cycle
   logic wr_cnt_l;           // data phase writes
   logic wr_cnt_h;
   logic wr_rld_l;
   logic wr_rld_h;
   logic wr_ctrl;
   logic wr_any;             // any write to count or reload
   logic addr_ok;            // accepted address phase
   logic [7:0] wdat;         // write byte, low lane only

   // ==========================================
   // source synchronisers
   // sync before use
   rct_edge_sync u_rtc_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(rtc_osc),
      .rise(rtc_rise)
   );

   rct_edge_sync u_ext_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(ext_osc),
      .rise(ext_rise)
   );

   // ==========================================
   // prescalers
   // system_clock over twelve
   rct_pulse_div #(
      .DIVIDE(SYS_DIV)
   ) u_div12 (
      .clk(clk),
      .sys_rst(sys_rst),
      .pulse_in(1'b1),
      .pulse_out(tick12)
   );

   rct_pulse_div #(
      .DIVIDE(EXT_DIV)
   ) u_div8 (
      .clk(clk),
      .sys_rst(sys_rst),
      .pulse_in(ext_rise),
      .pulse_out(ext8)
   );

   // ==========================================
   // read mux, registered in the address phase
   // unmapped offsets read zero; upper bits always zero
   function automatic logic [31:0] read_word(input rct_state_type s, input logic [7:0] a);
      logic [31:0] w;
      w = RST32;
      case (a)
         OFF_CNT_L: w[7:0] = s.cnt[7:0];
         OFF_CNT_H: w[7:0] = s.cnt[15:8];
         OFF_RLD_L: w[7:0] = s.rld[7:0];
         OFF_RLD_H: w[7:0] = s.rld[15:8];
         OFF_CTRL: w[7:0] = {s.tf_h, s.tf_l, s.len, s.cap_en, s.split, s.run, s.xclk};
         OFF_CLOCK_CONTROL_REGISTER: begin
            w[B_SEL_L] = s.sel_l;
            w[B_SEL_H] = s.sel_h;
         end
         OFF_IEN: w[B_TIMER_IE] = s.irq_en;
         default: w = RST32;
      endcase
      return w;
   endfunction

   // ==========================================
   // clock source selection
   always_comb begin
      case (st.xclk)
         XCLK_DIV12: ext_tick = tick12;
         XCLK_RTC: ext_tick = rtc_rise;
         XCLK_EXT8: ext_tick = ext8;
         // reserved code: byte stops unless on system clock
         default: ext_tick = 1'b0;
      endcase
      // select bit one means system clock
      tick_l = st.sel_l ? 1'b1 : ext_tick;
      tick_h = st.sel_h ? 1'b1 : ext_tick;
      trig = st.xclk[B_XCLK1] ? ext8 : rtc_rise;
   end

   // ==========================================
   // bus decode
   always_comb begin
      // only NONSEQ/SEQ with hready open an access
      addr_ok = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
      wdat = ahb_in.hwdata[7:0];
      wr_cnt_l = st.wr_pend && (st.wr_addr == OFF_CNT_L);
      wr_cnt_h = st.wr_pend && (st.wr_addr == OFF_CNT_H);
      wr_rld_l = st.wr_pend && (st.wr_addr == OFF_RLD_L);
      wr_rld_h = st.wr_pend && (st.wr_addr == OFF_RLD_H);
      wr_ctrl = st.wr_pend && (st.wr_addr == OFF_CTRL);
      wr_any = wr_cnt_l | wr_cnt_h | wr_rld_l | wr_rld_h;
   end

   // ==========================================
   // next state: counting, writes, capture, flags
   always_comb begin
      next_st = st;
      ovf_l = 1'b0;
      ovf_h = 1'b0;
      cap_set = 1'b0;

      if (!st.split) begin
         // one 16-bit count, low byte clock drives it
         if (st.run && tick_l) begin
            ovf_l = (st.cnt[7:0] == BYTE_MAX);
            if (st.cnt == CNT_MAX16) begin
               ovf_h = 1'b1;
               if (st.cap_en) begin
                  next_st.cnt = RST16;
               end else begin
                  next_st.cnt = st.rld;
               end
            end else begin
               next_st.cnt = st.cnt + 16'h0001;
            end
         end
      end else begin
         // low byte on its own reload
         if (tick_l) begin
            ovf_l = (st.cnt[7:0] == BYTE_MAX);
            next_st.cnt[7:0] = ovf_l ? st.rld[7:0] : st.cnt[7:0] + 8'h01;
         end
         if (st.run && tick_h) begin
            ovf_h = (st.cnt[15:8] == BYTE_MAX);
            next_st.cnt[15:8] = ovf_h ? st.rld[15:8] : st.cnt[15:8] + 8'h01;
         end
      end

      // software writes win over counting
      if (wr_cnt_l) begin
         next_st.cnt[7:0] = wdat;
      end
      if (wr_cnt_h) begin
         next_st.cnt[15:8] = wdat;
      end
      if (wr_rld_l) begin
         next_st.rld[7:0] = wdat;
      end
      if (wr_rld_h) begin
         next_st.rld[15:8] = wdat;
      end
      if (wr_ctrl) begin
         next_st.tf_h = wdat[B_TFH];
         next_st.tf_l = wdat[B_TFL];
         next_st.len = wdat[B_LEN];
         next_st.cap_en = wdat[B_CEN];
         next_st.split = wdat[B_SPLIT];
         next_st.run = wdat[B_RUN];
         next_st.xclk = wdat[B_XCLK1:B_XCLK0];
      end
      if (st.wr_pend && (st.wr_addr == OFF_CLOCK_CONTROL_REGISTER)) begin
         next_st.sel_l = wdat[B_SEL_L];
         next_st.sel_h = wdat[B_SEL_H];
      end
      if (st.wr_pend && (st.wr_addr == OFF_IEN)) begin
         next_st.irq_en = wdat[B_TIMER_IE];
      end

      // trig is a one-cycle edge pulse
      if (st.cap_en && trig) begin
         cap_set = 1'b1;
         // capture beats a reload write in the same cycle
         next_st.rld = st.cnt;
      end

      // hardware only sets, set beats clear
      next_st.tf_h = next_st.tf_h | ovf_h | cap_set;
      next_st.tf_l = next_st.tf_l | ovf_l;

      next_st.irq = next_st.irq_en & (next_st.tf_h | (next_st.tf_l & next_st.len));

      // address phase capture; reads sampled here
      next_st.wr_pend = addr_ok & ahb_in.hwrite;
      next_st.wr_addr = ahb_in.haddr[7:0];
      if (addr_ok && !ahb_in.hwrite) begin
         next_st.rdata = read_word(st, ahb_in.haddr[7:0]);
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // outputs: zero wait states, always OKAY
   always_comb begin
      ahb_out.hreadyout = 1'b1;
      ahb_out.hresp = 1'b0;
      ahb_out.hrdata = st.rdata;
   end

   assign irq = st.irq;

   // ==========================================
   // checks
   // no self clear
   flag_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st.tf_h && !wr_ctrl) |=> st.tf_h)
      else $error("high flag cleared without a software write");

   wrap_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!st.split && !st.cap_en && st.run && tick_l && st.cnt == CNT_MAX16 && !wr_any)
      |=> (st.cnt == $past(st.rld)) && st.tf_h)
      else $error("16-bit wrap did not load reload value");

   cap_free_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!st.split && st.cap_en && st.run && tick_l && st.cnt == CNT_MAX16 && !wr_any && !trig)
      |=> st.cnt == RST16)
      else $error("capture mode count did not wrap to zero");

   irq_high_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st.tf_h && st.irq_en) |-> irq)
      else $error("enabled high flag gave no interrupt");

   irq_low_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st.tf_l && !st.tf_h) |-> (irq == (st.irq_en && st.len)))
      else $error("low byte interrupt enable not honoured");

   split_low_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st.split && !st.run && st.sel_l && !wr_any && st.cnt[7:0] != BYTE_MAX)
      |=> (st.cnt[7:0] == $past(st.cnt[7:0]) + 8'h01) && $stable(st.cnt[15:8]))
      else $error("split low byte stalled or high byte ran");

   split_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st.split && tick_l && st.cnt[7:0] == BYTE_MAX && !wr_any)
      |=> (st.cnt[7:0] == $past(st.rld[7:0])) && st.tf_l)
      else $error("split low wrap did not reload or flag");

   capture_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st.cap_en && trig) |=> (st.rld == $past(st.cnt)) && st.tf_h)
      else $error("capture did not copy count into reload");

   trig_once_a: assert property (@(posedge clk) disable iff (sys_rst)
      rtc_rise |=> !rtc_rise)
      else $error("rtc edge gave more than one pulse");

   tick_space_a: assert property (@(posedge clk) disable iff (sys_rst)
      tick12 |=> !tick12 [*8])
      else $error("system clock prescaler ticks too close");

   // exact twelve cycle period, catches a wrong divide value
   tick_period_a: assert property (@(posedge clk) disable iff (sys_rst)
      tick12 |-> ##12 tick12)
      else $error("system clock prescaler period is not twelve");

   // split high byte wrap reloads and flags
   split_high_a: assert property (@(posedge clk) disable iff (sys_rst)
      (st.split && st.run && tick_h && st.cnt[15:8] == BYTE_MAX && !wr_any)
      |=> (st.cnt[15:8] == $past(st.rld[15:8])) && st.tf_h)
      else $error("split high wrap did not reload or flag");

   // low byte wrap in 16-bit mode feeds the low request
   low_flag16_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!st.split && st.run && tick_l && st.cnt[7:0] == BYTE_MAX) |=> st.tf_l)
      else $error("16-bit low byte wrap did not set its flag");

endmodule
